// ===== shared/dpe_pkg.sv
// constants for the discovery payload tail encoder
package dpe_pkg;
   localparam int unsigned seg_count = 8;
   localparam int unsigned pwr_count = 4;
   localparam logic [7:0] crc_poly = 8'h07;
   localparam logic [7:0] crc_seed = 8'h00;
   localparam logic [7:0] pad_byte = 8'h00;
   localparam logic [2:0] lane_code_x16 = 3'h4;
   localparam logic [3:0] enum_order_first = 4'h0;
   localparam logic [7:0] size_unit = 8'h08;
   localparam int unsigned size_shift = 3;
   localparam logic [0:0] kind_hsio = 1'h0;
   localparam logic [0:0] kind_power = 1'h1;
   localparam logic [3:0] offset_natural = 4'h0;
   localparam logic [3:0] offset_rev_x8 = 4'h7;
   // byte positions inside the tail, counted from the first emitted byte
   localparam logic [7:0] pos_order = 8'h00;
   localparam logic [7:0] pos_first = 8'h01;
   localparam logic [7:0] pos_second = 8'h02;
   localparam logic [7:0] pos_src0 = 8'h03;
   localparam logic [7:0] pos_src1 = 8'h04;
   localparam logic [7:0] tail_used = 8'h05;
   typedef enum logic [3:0] {
      st_idle = 4'b0001,
      st_send = 4'b0010,
      st_pad = 4'b0100,
      st_crc = 4'b1000
   } dpe_state_type;
endpackage : dpe_pkg

// ===== rtl/dpe_encoder.sv
// discovery payload tail encoder: routing fields, source wire descriptor, crc-8
module dpe_encoder (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // endpoint routing configuration
   input wire logic behind_switch_flag,
   input wire logic [3:0] switch_port_enum_order,
   input wire logic [2:0] endpoint_lane_count_code,
   input wire logic [2:0] lane_source_connector_idx,
   input wire logic [3:0] first_lane_offset,
   input wire logic [2:0] second_connector_idx,
   input wire logic [3:0] second_lane_offset,
   input wire logic frame_link_source_kind,
   input wire logic [2:0] frame_link_source_idx,
   // bytes already emitted before the tail (header and endpoint start)
   input wire logic [7:0] prefix_len,
   input wire logic [7:0] prefix_crc,
   // presence wires from the connectors, asynchronous
   input wire logic [7:0] cable_presence_wire,
   input wire logic [3:0] power_presence_wire,
   input wire logic stimulus_phase,
   // byte stream out
   input wire logic start,
   input wire logic byte_ready,
   output logic byte_valid,
   output logic [7:0] byte_data,
   output logic byte_last,
   output logic busy,
   // length code of the whole payload
   output logic [7:0] static_size_code
);
   function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] din);
      logic [7:0] c;
      c = crc ^ din;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ dpe_pkg::crc_poly) : (c << 1);
      end
      return c;
   endfunction : crc8_step

   dpe_pkg::dpe_state_type state_q, state_d;
   logic [7:0] pos_q, pos_d;
   logic [7:0] crc_q, crc_d;
   logic [7:0] pad_left_q, pad_left_d;
   logic [7:0] cab_m_q, cab_s_q;
   logic [3:0] pwr_m_q, pwr_s_q;
   logic stim_m_q, stim_s_q;
   // output bytes leave from flops so the initiator sees no decode glitches
   logic [7:0] byte_data_q;
   logic [7:0] size_q;

   // two-flop synchronisers; only the second stage is read
   always_ff @(posedge ref_clk) begin
      cab_m_q <= cable_presence_wire;
      cab_s_q <= cab_m_q;
      pwr_m_q <= power_presence_wire;
      pwr_s_q <= pwr_m_q;
      stim_m_q <= stimulus_phase;
      stim_s_q <= stim_m_q;
   end

   // routing bytes
   wire is_x16 = (endpoint_lane_count_code == dpe_pkg::lane_code_x16);
   wire [3:0] order_field = behind_switch_flag ? switch_port_enum_order
      : dpe_pkg::enum_order_first;
   wire [7:0] byte_order = {order_field, endpoint_lane_count_code, behind_switch_flag};
   wire [7:0] byte_first = {1'b0, lane_source_connector_idx, first_lane_offset};
   // only an x16 endpoint fills both of these fields; any other lane count leaves the second as pad
   wire [7:0] byte_second = is_x16 ? {1'b0, second_connector_idx, second_lane_offset}
      : dpe_pkg::pad_byte;

   // markers: static one outside stimulus, live wires during it
   wire [7:0] fab_live = stim_s_q ? cab_s_q : 8'hff;
   wire [3:0] pwr_live = stim_s_q ? pwr_s_q : 4'hf;
   // the frame wire cannot be traced by stimulus, so its marker stays set
   wire [7:0] fab_comm = (frame_link_source_kind == dpe_pkg::kind_hsio)
      ? (8'h01 << frame_link_source_idx) : 8'h00;
   wire [3:0] pwr_comm = (frame_link_source_kind == dpe_pkg::kind_power)
      ? (4'h1 << frame_link_source_idx[1:0]) : 4'h0;
   wire [7:0] byte_src0 = {pwr_live | pwr_comm, frame_link_source_kind,
      frame_link_source_idx};
   wire [7:0] byte_src1 = fab_live | fab_comm;

   // total length rounded up to a multiple of eight, checksum included
   wire [7:0] raw_len = prefix_len + dpe_pkg::tail_used + 8'h01;
   wire [7:0] tot_len = (raw_len + dpe_pkg::size_unit - 8'h01) & ~(dpe_pkg::size_unit - 8'h01);
   wire [7:0] pad_cnt = tot_len - raw_len;
   wire [7:0] size_d = tot_len >> dpe_pkg::size_shift;
   // one cycle behind prefix_len; it is settled long before the tail starts
   assign static_size_code = size_q;

   // field for the position that will be shown next cycle, so it can be registered
   logic [7:0] field_byte;
   always_comb begin
      case (pos_d)
         dpe_pkg::pos_order: field_byte = byte_order;
         dpe_pkg::pos_first: field_byte = byte_first;
         dpe_pkg::pos_second: field_byte = byte_second;
         dpe_pkg::pos_src0: field_byte = byte_src0;
         dpe_pkg::pos_src1: field_byte = byte_src1;
         default: field_byte = dpe_pkg::pad_byte;
      endcase
   end

   wire send_st = (state_q == dpe_pkg::st_send);
   wire pad_st = (state_q == dpe_pkg::st_pad);
   wire crc_st = (state_q == dpe_pkg::st_crc);
   assign byte_valid = send_st | pad_st | crc_st;
   wire next_crc = (state_d == dpe_pkg::st_crc);
   wire next_pad = (state_d == dpe_pkg::st_pad);
   // the crc byte takes crc_d so the byte that enters crc is already folded in
   wire [7:0] data_d = next_crc ? crc_d
      : (next_pad ? dpe_pkg::pad_byte : field_byte);
   assign byte_data = byte_data_q;
   assign byte_last = crc_st;
   assign busy = (state_q != dpe_pkg::st_idle);
   wire take = byte_valid & byte_ready;

   always_comb begin
      state_d = state_q;
      pos_d = pos_q;
      crc_d = crc_q;
      pad_left_d = pad_left_q;
      case (state_q)
         dpe_pkg::st_idle: begin
            if (start) begin
               state_d = dpe_pkg::st_send;
               pos_d = 8'h00;
               crc_d = prefix_crc; // running crc over the header, seeded with crc_seed upstream
               pad_left_d = pad_cnt;
            end
         end
         dpe_pkg::st_send: begin
            if (take) begin
               // fold in exactly the byte the initiator takes
               crc_d = crc8_step(crc_q, byte_data_q);
               pos_d = pos_q + 8'h01;
               if (pos_q == dpe_pkg::tail_used - 8'h01) begin
                  state_d = (pad_left_q == 8'h00) ? dpe_pkg::st_crc : dpe_pkg::st_pad;
               end
            end
         end
         dpe_pkg::st_pad: begin
            if (take) begin
               crc_d = crc8_step(crc_q, dpe_pkg::pad_byte);
               pad_left_d = pad_left_q - 8'h01;
               if (pad_left_q == 8'h01) begin
                  state_d = dpe_pkg::st_crc;
               end
            end
         end
         dpe_pkg::st_crc: begin
            if (take) begin
               state_d = dpe_pkg::st_idle;
            end
         end
         default: state_d = dpe_pkg::st_idle;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q <= dpe_pkg::st_idle;
         pos_q <= 8'h00;
         crc_q <= dpe_pkg::crc_seed;
         pad_left_q <= 8'h00;
      end else begin
         state_q <= state_d;
         pos_q <= pos_d;
         crc_q <= crc_d;
         pad_left_q <= pad_left_d;
      end
   end

   // data outputs; recomputed every cycle so a stall keeps the same byte, except the live marker bytes during stimulus
   // limitation: fields read the routing inputs live, which must stay still during a tail
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         byte_data_q <= dpe_pkg::pad_byte;
         size_q <= 8'h00;
      end else begin
         byte_data_q <= data_d;
         size_q <= size_d;
      end
   end
endmodule : dpe_encoder

// ===== sim/dpe_checker.sv
// assertions on the tail encoder ports
module dpe_checker (
   input wire logic ref_clk, rst, busy, byte_ready, byte_valid, byte_last,
   input wire logic behind_switch_flag, frame_link_source_kind,
   input wire logic [2:0] endpoint_lane_count_code, frame_link_source_idx,
   input wire logic [2:0] lane_source_connector_idx,
   input wire logic [3:0] first_lane_offset,
   input wire logic [3:0] switch_port_enum_order,
   input wire logic [7:0] prefix_len, byte_data, static_size_code
);
   logic [7:0] k_q;
   wire [7:0] k = byte_valid ? k_q : 8'hff;
   wire [7:0] tot = prefix_len + k_q + 8'h01;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // tail byte index; idle clears it so a refused start cannot skew it
   always_ff @(posedge ref_clk) k_q <= (rst || !busy) ? 8'h00 : k_q + 8'(byte_valid && byte_ready);
   property p_b0; k == 8'h00 |-> byte_data == {behind_switch_flag ? switch_port_enum_order : 4'h0,
      endpoint_lane_count_code, behind_switch_flag}; endproperty
   a_b0: assert property (p_b0) else $error("bad order byte");
   property p_b1; k == 8'h01 |->
      byte_data == {1'b0, lane_source_connector_idx, first_lane_offset}; endproperty
   a_b1: assert property (p_b1) else $error("bad routing byte");
   property p_b2; k == 8'h02 && endpoint_lane_count_code != 3'h4 |-> byte_data == 8'h00; endproperty
   a_b2: assert property (p_b2) else $error("second routing byte set");
   property p_b3; k == 8'h03 |->
      byte_data[3:0] == {frame_link_source_kind, frame_link_source_idx}; endproperty
   a_b3: assert property (p_b3) else $error("bad frame source");
   property p_mk; k == 8'h03 && frame_link_source_kind |->
      byte_data[3'h4 + frame_link_source_idx[1:0]]; endproperty
   a_mk: assert property (p_mk) else $error("frame marker clear");
   property p_mf; k == 8'h04 && !frame_link_source_kind |->
      byte_data[frame_link_source_idx]; endproperty
   a_mf: assert property (p_mf) else $error("frame fabric marker clear");
   property p_pad; k > 8'h04 && k < 8'hff && !byte_last |-> byte_data == 8'h00; endproperty
   a_pad: assert property (p_pad) else $error("pad not zero");
   property p_len; byte_valid && byte_last |-> tot[2:0] == 3'h0; endproperty
   a_len: assert property (p_len) else $error("bad length");
   property p_sz; byte_valid && byte_last |-> static_size_code == {3'h0, tot[7:3]}; endproperty
   a_sz: assert property (p_sz) else $error("bad size code");
   cover property (byte_valid && !byte_ready);
   cover property (k == 8'h02 && endpoint_lane_count_code == 3'h4);
   cover property (byte_last && byte_ready);
endmodule : dpe_checker
bind dpe_encoder dpe_checker dpe_checker_inst (.*);

// ===== sim/dpe_sink.sv
// initiator stand-in: random stalls, keeps the bytes, runs the crc
module dpe_sink (
   input wire logic ref_clk, clr, byte_valid,
   input wire logic [7:0] prefix_crc, byte_data,
   output logic byte_ready = 1'b0,
   output logic [7:0] crc_q,
   output logic [7:0] rx [0:31],
   output int n
);
   timeunit 1ns;
   timeprecision 1ps;
   int s = 32'hcca9;
   // stalls on about one cycle in four test the hold of byte_data
   always @(negedge ref_clk) byte_ready <= ($random(s) & 3) != 0;
   always @(posedge ref_clk)
      if (clr) begin
         n <= 0;
         crc_q <= prefix_crc;
      end else if (byte_valid && byte_ready) begin
         rx[n] <= byte_data;
         n <= n + 1;
         crc_q <= crc8(crc_q ^ byte_data);
      end
   function automatic logic [7:0] crc8(input logic [7:0] c);
      repeat (8) c = {c[6:0], 1'b0} ^ (c[7] ? 8'h07 : 8'h00);
      return c;
   endfunction : crc8
endmodule : dpe_sink

// ===== sim/tb_discovery_payload_encoder.sv
// self-checking bench for the discovery payload tail encoder
module tb_discovery_payload_encoder;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0, rst = 1'b1, clr = 1'b1, start = 1'b0, stimulus_phase, busy;
   logic behind_switch_flag, frame_link_source_kind, byte_ready, byte_valid, byte_last;
   logic [3:0] switch_port_enum_order, first_lane_offset, second_lane_offset, power_presence_wire, p;
   logic [2:0] endpoint_lane_count_code, lane_source_connector_idx, second_connector_idx;
   logic [2:0] frame_link_source_idx;
   logic [7:0] prefix_len, prefix_crc, cable_presence_wire, byte_data, static_size_code, crc_q, m;
   logic [7:0] rx [0:31];
   int n, k, errors = 0, tests_run = 0, seed = 32'hcca9;
   dpe_encoder dpe_encoder_inst (.*);
   dpe_sink dpe_sink_inst (.*);
   task automatic check(input string what, input logic [7:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s exp %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic end_sim;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   task automatic pick(input logic [2:0] lc, input logic [3:0] off, input logic st);
      {behind_switch_flag, switch_port_enum_order, lane_source_connector_idx, second_connector_idx,
         second_lane_offset, frame_link_source_kind, frame_link_source_idx, power_presence_wire,
         cable_presence_wire, prefix_crc, prefix_len} = 47'({$random(seed), $random(seed)});
      prefix_len &= 8'h1f;
      endpoint_lane_count_code = lc;
      first_lane_offset = off;
      stimulus_phase = st;
   endtask : pick
   task automatic frame(input logic [2:0] lc, input logic [3:0] off, input logic st);
      pick(lc, off, st);
      clr = 1'b1;
      // three edges let the two-flop presence synchroniser settle
      repeat (3) @(negedge ref_clk);
      clr = 1'b0;
      start = 1'b1;
      @(negedge ref_clk);
      start = 1'b0;
      for (k = 0; k < 200 && busy === 1'b1; k++) @(negedge ref_clk);
      if (k == 200) begin
         errors++;
         end_sim();
      end
      check("crc", crc_q, 8'h00);
      check("size code", static_size_code, 8'(((prefix_len + 13) & ~7) / 8));
      check("length", 8'(n), 8'(((prefix_len + 13) & ~7) - prefix_len));
      check("order", rx[0], {behind_switch_flag ? switch_port_enum_order : 4'h0, lc,
         behind_switch_flag});
      check("first", rx[1], {1'b0, lane_source_connector_idx, off});
      check("source", {4'h0, rx[3][3:0]}, {4'h0, frame_link_source_kind,
         frame_link_source_idx});
      for (int j = 5; j < n - 1 && j < 32; j++) check("pad", rx[j], 8'h00);
      check("second", rx[2], lc == 3'h4 ? {1'b0, second_connector_idx, second_lane_offset} : 8'h00);
      p = st ? power_presence_wire : 4'hf;
      m = st ? cable_presence_wire : 8'hff;
      if (frame_link_source_kind) p[frame_link_source_idx[1:0]] = 1'b1;
      else m[frame_link_source_idx] = 1'b1;
      check("power markers", {rx[3][7:4], 4'h0}, {p, 4'h0});
      check("fabric markers", rx[4], m);
   endtask : frame
   initial begin
      pick(3'h4, 4'h7, 1'b0);
      repeat (8) @(negedge ref_clk);
      rst = 1'b0;
      frame(3'h4, 4'h7, 1'b0); // x16 pair, reversed x8 offset
      frame(3'h3, 4'h0, 1'b1); // x8 natural offset, markers follow wires
      for (int i = 0; i < 40; i++) frame(3'(i), 4'(i), i[3]);
      end_sim();
   end
   initial forever #5 ref_clk = ~ref_clk;
endmodule : tb_discovery_payload_encoder
